// *** rtl/mesh_router_pkg.sv ***
package mesh_router_pkg;

	// ----------------------------------------------------------------
	// networks and ports
	// ----------------------------------------------------------------
	localparam int NUM_NET = 3;
	localparam int NET_ONCHIP = 0;
	localparam int NET_READ = 1;
	localparam int NET_OFFCHIP = 2;
	localparam int NUM_DIR = 5;
	localparam int NUM_LINK = 4;
	localparam int DIR_NORTH = 0;
	localparam int DIR_EAST = 1;
	localparam int DIR_WEST = 2;
	localparam int DIR_SOUTH = 3;
	localparam int DIR_LOCAL = 4;

	// ----------------------------------------------------------------
	// address layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int TAG_W = 6;
	localparam int ROW_HI = 31;
	localparam int ROW_LO = 26;
	localparam int COL_HI = 25;
	localparam int COL_LO = 20;
	localparam int LOCAL_HI = 31;
	localparam int LOCAL_LO = 20;
	localparam int CHIP_ROW_BITS = 2;
	localparam int CHIP_COL_BITS = 2;

	// ----------------------------------------------------------------
	// modes, overrides, timing
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_MULTICAST = 4'h3;
	localparam int OVR_W = 3;
	localparam logic [2:0] OVR_NORMAL = 3'h0;
	localparam logic [2:0] OVR_BLOCK = 3'h7;
	localparam int READ_GAP_CYCLES = 8;
	localparam int GAP_W = 3;

	// ----------------------------------------------------------------
	// apb register map and reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] REG_MODE = 12'h000;
	localparam logic [11:0] REG_GROUP = 12'h004;
	localparam logic [11:0] REG_OVR_ONCHIP = 12'h008;
	localparam logic [11:0] REG_OVR_OFFCHIP = 12'h00c;
	localparam logic [11:0] REG_OVR_READ = 12'h010;
	localparam logic [11:0] REG_STATUS = 12'h014;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [31:0] GROUP_RST = 32'h00000000;
	localparam logic [2:0] OVR_RST = 3'h0;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_HALF = 2'h1,
		SIZE_WORD = 2'h2,
		SIZE_DOUBLE = 2'h3
	} size_t;

	typedef struct packed {
		logic [31:0] dst_addr;
		logic [31:0] src_addr;
		logic [63:0] data;
		size_t size;
		logic mcast;
	} flit_t;

	typedef struct packed {
		logic write;
		logic [31:0] dst_addr;
		logic [31:0] src_addr;
		logic [63:0] data;
		size_t size;
	} req_t;

endpackage : mesh_router_pkg

// *** rtl/rr_arbiter.sv ***
`timescale 1ns/10ps
module rr_arbiter #(
	parameter int N = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// requests and grant
	input wire logic [N-1:0] req,
	input wire logic advance,
	output logic [N-1:0] grant
);

	localparam int PW = $clog2(N);
	logic [PW-1:0] ptr_ff;
	logic [PW-1:0] nxt_ptr;
	int idx;

	// search starts just after the last winner, so every requester gets a turn
	always_comb begin
		grant = '0;
		nxt_ptr = ptr_ff;
		idx = 0;
		for (int k = N - 1; k >= 0; k--) begin
			idx = (int'(ptr_ff) + k) % N;
			if (req[idx]) begin
				grant = '0;
				grant[idx] = 1'b1;
				nxt_ptr = PW'((idx + 1) % N);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_ff <= '0;
		end else if (advance && (|grant)) begin
			ptr_ff <= nxt_ptr;
		end
	end

endmodule : rr_arbiter

// *** rtl/mesh_node_router.sv ***
// How it works
// - route only on top twelve address bits; the code matches multicast node entry on all 32 dst_addr bits against group_ff
// - six row bits, six column bits compared
// - column tag smaller: forward east
// - column tag larger: forward west
// - finish column travel before row travel
// - column matched: smaller row north, larger south
// - both tags match: deliver into node
// - posted reads routed on read network
// - read requests carry requester return address
// - target answers reads as writes to return address
// - round-robin arbitration in every router output
// - byte to doubleword, data right-justified
// - multicast spreads radially, ignoring tags
// - multicast enters node on group match
// - per-network override blocks or redirects traffic
// - address bits 31:20 zero means local
// - arbitrate competing local sources
// - one transaction issued per clock cycle
// - doubleword writes every cycle without stall
// - three separate networks: onchip, read, offchip
// - registered hop keeps per-hop latency low
// - read network: one request per eight cycles per link direction
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module mesh_node_router #(
	parameter int NUM_SRC = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// node identity
	input wire logic [5:0] node_row,
	input wire logic [5:0] node_col,
	// neighbour links, per network and direction
	input wire logic [mesh_router_pkg::NUM_LINK-1:0] link_in_valid [mesh_router_pkg::NUM_NET],
	input mesh_router_pkg::flit_t link_in_flit [mesh_router_pkg::NUM_NET][mesh_router_pkg::NUM_LINK],
	output logic [mesh_router_pkg::NUM_LINK-1:0] link_in_ready [mesh_router_pkg::NUM_NET],
	output logic [mesh_router_pkg::NUM_LINK-1:0] link_out_valid [mesh_router_pkg::NUM_NET],
	output mesh_router_pkg::flit_t link_out_flit [mesh_router_pkg::NUM_NET][mesh_router_pkg::NUM_LINK],
	input wire logic [mesh_router_pkg::NUM_LINK-1:0] link_out_ready [mesh_router_pkg::NUM_NET],
	// local masters
	input wire logic [NUM_SRC-1:0] src_valid,
	input mesh_router_pkg::req_t src_req [NUM_SRC],
	output logic [NUM_SRC-1:0] src_ready,
	// delivery into the node, per network
	output logic [mesh_router_pkg::NUM_NET-1:0] node_out_valid,
	output mesh_router_pkg::flit_t node_out_flit [mesh_router_pkg::NUM_NET],
	input wire logic [mesh_router_pkg::NUM_NET-1:0] node_out_ready,
	// local memory port
	output logic lmem_valid,
	output mesh_router_pkg::req_t lmem_req,
	input wire logic lmem_ready
);

	localparam int NN = mesh_router_pkg::NUM_NET;
	localparam int ND = mesh_router_pkg::NUM_DIR;
	localparam int NL = mesh_router_pkg::NUM_LINK;
	localparam int LOC = mesh_router_pkg::DIR_LOCAL;

	// ----------------------------------------------------------------
	// node id capture
	// ----------------------------------------------------------------
	logic [5:0] row_s1_ff;
	logic [5:0] row_ff;
	logic [5:0] col_s1_ff;
	logic [5:0] col_ff;

	// straps come from outside the clock domain, so two stages first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_s1_ff <= '0;
			row_ff <= '0;
			col_s1_ff <= '0;
			col_ff <= '0;
		end else begin
			row_s1_ff <= node_row;
			row_ff <= row_s1_ff;
			col_s1_ff <= node_col;
			col_ff <= col_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:0] mode_ff;
	logic [31:0] group_ff;
	logic [2:0] ovr_ff [NN];
	logic [31:0] prdata_ff;
	logic [31:0] rd_mux;
	logic unmapped;
	logic apb_wr;
	logic [NN-1:0] inj_valid_ff;
	logic [ND-1:0] out_valid_ff [NN];
	logic lmem_valid_ff;

	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && unmapped;
	assign prdata = prdata_ff;

	always_comb begin
		rd_mux = '0;
		unmapped = 1'b0;
		unique case (paddr)
			mesh_router_pkg::REG_MODE: rd_mux = {28'h0000000, mode_ff};
			mesh_router_pkg::REG_GROUP: rd_mux = group_ff;
			mesh_router_pkg::REG_OVR_ONCHIP:
				rd_mux = {29'h00000000, ovr_ff[mesh_router_pkg::NET_ONCHIP]};
			mesh_router_pkg::REG_OVR_OFFCHIP:
				rd_mux = {29'h00000000, ovr_ff[mesh_router_pkg::NET_OFFCHIP]};
			mesh_router_pkg::REG_OVR_READ:
				rd_mux = {29'h00000000, ovr_ff[mesh_router_pkg::NET_READ]};
			mesh_router_pkg::REG_STATUS: rd_mux = {13'h0000, lmem_valid_ff, inj_valid_ff,
				out_valid_ff[2], out_valid_ff[1], out_valid_ff[0]};
			default: unmapped = 1'b1;
		endcase
	end

	// read data is captured in the setup cycle, so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= mesh_router_pkg::MODE_RST;
			group_ff <= mesh_router_pkg::GROUP_RST;
			for (int n = 0; n < NN; n++) begin
				ovr_ff[n] <= mesh_router_pkg::OVR_RST;
			end
		end else if (apb_wr) begin
			if (paddr == mesh_router_pkg::REG_MODE) begin
				mode_ff <= pwdata[3:0];
			end
			if (paddr == mesh_router_pkg::REG_GROUP) begin
				group_ff <= pwdata;
			end
			if (paddr == mesh_router_pkg::REG_OVR_ONCHIP) begin
				ovr_ff[mesh_router_pkg::NET_ONCHIP] <= pwdata[2:0];
			end
			if (paddr == mesh_router_pkg::REG_OVR_OFFCHIP) begin
				ovr_ff[mesh_router_pkg::NET_OFFCHIP] <= pwdata[2:0];
			end
			if (paddr == mesh_router_pkg::REG_OVR_READ) begin
				ovr_ff[mesh_router_pkg::NET_READ] <= pwdata[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// route decision
	// ----------------------------------------------------------------
	function automatic logic [4:0] route_dirs(input mesh_router_pkg::flit_t f, input int port,
			input logic [2:0] ovr, input logic [5:0] row, input logic [5:0] col,
			input logic [31:0] group, input logic mcast_ok);
		logic [5:0] drow;
		logic [5:0] dcol;
		logic [4:0] r;
		drow = f.dst_addr[mesh_router_pkg::ROW_HI:mesh_router_pkg::ROW_LO];
		dcol = f.dst_addr[mesh_router_pkg::COL_HI:mesh_router_pkg::COL_LO];
		r = '0;
		if (ovr == mesh_router_pkg::OVR_BLOCK) begin
			r = '0;
		end else if (ovr != mesh_router_pkg::OVR_NORMAL) begin
			r = 5'(5'h01 << (ovr - 3'h1));
		end else if (f.mcast && mcast_ok) begin
			// radial spread: rows fan out to columns, columns only continue outward
			unique case (port)
				mesh_router_pkg::DIR_EAST: r = 5'h0d;
				mesh_router_pkg::DIR_WEST: r = 5'h0b;
				mesh_router_pkg::DIR_NORTH: r = 5'h08;
				mesh_router_pkg::DIR_SOUTH: r = 5'h01;
				default: r = 5'h0f;
			endcase
			if (port != LOC && f.dst_addr == group) begin
				r[LOC] = 1'b1;
			end
		end else if (dcol < col) begin
			r[mesh_router_pkg::DIR_EAST] = 1'b1;
		end else if (dcol > col) begin
			r[mesh_router_pkg::DIR_WEST] = 1'b1;
		end else if (drow < row) begin
			r[mesh_router_pkg::DIR_NORTH] = 1'b1;
		end else if (drow > row) begin
			r[mesh_router_pkg::DIR_SOUTH] = 1'b1;
		end else begin
			r[LOC] = 1'b1;
		end
		return r;
	endfunction : route_dirs

	// ----------------------------------------------------------------
	// crossbar per network
	// ----------------------------------------------------------------
	mesh_router_pkg::flit_t inj_flit_ff [NN];
	mesh_router_pkg::flit_t all_flit [NN][ND];
	mesh_router_pkg::flit_t out_flit_ff [NN][ND];
	logic [ND-1:0] all_valid [NN];
	logic [ND-1:0] all_ready [NN];
	logic [ND-1:0] want [NN][ND];
	logic [ND-1:0] grant [NN][ND];
	logic [ND-1:0] served [NN][ND];
	logic [ND-1:0] sent_ff [NN][ND];
	logic [ND-1:0] take [NN];
	logic [ND-1:0] out_ready [NN];
	localparam int GAP_W_L = mesh_router_pkg::GAP_W;
	logic [GAP_W_L-1:0] gap_ff [NN][ND];

	always_comb begin
		for (int n = 0; n < NN; n++) begin
			for (int i = 0; i < ND; i++) begin
				all_flit[n][i] = (i == LOC) ? inj_flit_ff[n] : link_in_flit[n][i % NL];
				all_valid[n][i] = (i == LOC) ? inj_valid_ff[n] : link_in_valid[n][i % NL];
				want[n][i] = '0;
				if (all_valid[n][i]) begin
					want[n][i] = route_dirs(all_flit[n][i], i, ovr_ff[n], row_ff, col_ff,
						group_ff, n != mesh_router_pkg::NET_READ) & ~sent_ff[n][i];
				end
				for (int o = 0; o < ND; o++) begin
					served[n][i][o] = grant[n][o][i] & take[n][o];
				end
				// an input leaves only when every output it needs has taken it
				all_ready[n][i] = (want[n][i] & ~served[n][i]) == '0;
			end
		end
	end

	for (genvar n = 0; n < NN; n++) begin : g_net
		assign link_in_ready[n] = all_ready[n][NL-1:0];
		assign out_ready[n] = {node_out_ready[n], link_out_ready[n]};
		assign link_out_valid[n] = out_valid_ff[n][NL-1:0];
		assign node_out_valid[n] = out_valid_ff[n][LOC];
		// read requests arrive here with their return address for the node to answer
		assign node_out_flit[n] = out_flit_ff[n][LOC];
		for (genvar o = 0; o < ND; o++) begin : g_out
			logic [ND-1:0] req_col;
			logic gap_ok;
			if (o < NL) begin : g_link
				assign link_out_flit[n][o] = out_flit_ff[n][o];
			end
			for (genvar i = 0; i < ND; i++) begin : g_req
				assign req_col[i] = want[n][i][o];
			end
			assign gap_ok = (n != mesh_router_pkg::NET_READ) || (o == LOC)
				|| (gap_ff[n][o] == '0);
			// refill in the same cycle the slot drains keeps one flit per cycle
			assign take[n][o] = gap_ok && (!out_valid_ff[n][o] || out_ready[n][o]);

			rr_arbiter #(
				.N(ND)
			) u_arb (
				.pclk(pclk),
				.presetn(presetn),
				.req(req_col),
				.advance(take[n][o]),
				.grant(grant[n][o])
			);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					out_valid_ff[n][o] <= 1'b0;
					out_flit_ff[n][o] <= '0;
				end else if (take[n][o] && (|req_col)) begin
					out_valid_ff[n][o] <= 1'b1;
					for (int i = 0; i < ND; i++) begin
						if (grant[n][o][i]) begin
							out_flit_ff[n][o] <= all_flit[n][i];
						end
					end
				end else if (out_ready[n][o]) begin
					out_valid_ff[n][o] <= 1'b0;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					gap_ff[n][o] <= '0;
				end else if (take[n][o] && (|req_col)) begin
					gap_ff[n][o] <= GAP_W_L'(mesh_router_pkg::READ_GAP_CYCLES - 1);
				end else if (gap_ff[n][o] != '0) begin
					gap_ff[n][o] <= gap_ff[n][o] - 1'b1;
				end
			end
		end

		// remembers which multicast branches already left, so none repeats
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				for (int i = 0; i < ND; i++) begin
					sent_ff[n][i] <= '0;
				end
			end else begin
				for (int i = 0; i < ND; i++) begin
					if (!all_valid[n][i] || all_ready[n][i]) begin
						sent_ff[n][i] <= '0;
					end else begin
						sent_ff[n][i] <= sent_ff[n][i] | served[n][i];
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// network interface
	// ----------------------------------------------------------------
	logic [1:0] tgt [NUM_SRC];
	logic [NUM_SRC-1:0] eligible;
	logic [NUM_SRC-1:0] src_grant;
	logic [3:0] slot_free;
	mesh_router_pkg::req_t lmem_req_ff;
	mesh_router_pkg::flit_t win_flit;
	logic [1:0] win_tgt;
	logic win_any;
	logic [63:0] win_data;

	function automatic logic [63:0] justify(input logic [63:0] d, input mesh_router_pkg::size_t s);
		logic [63:0] m;
		m = '0;
		unique case (s)
			mesh_router_pkg::SIZE_BYTE: m = {56'h0, d[7:0]};
			mesh_router_pkg::SIZE_HALF: m = {48'h0, d[15:0]};
			mesh_router_pkg::SIZE_WORD: m = {32'h0, d[31:0]};
			mesh_router_pkg::SIZE_DOUBLE: m = d;
		endcase
		return m;
	endfunction : justify

	assign lmem_valid = lmem_valid_ff;
	assign lmem_req = lmem_req_ff;

	always_comb begin
		for (int t = 0; t < NN; t++) begin
			slot_free[t] = !inj_valid_ff[t] || all_ready[t][LOC];
		end
		slot_free[3] = !lmem_valid_ff || lmem_ready;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (src_req[s].dst_addr[mesh_router_pkg::LOCAL_HI:mesh_router_pkg::LOCAL_LO] == '0) begin
				tgt[s] = 2'h3;
			end else if (!src_req[s].write) begin
				tgt[s] = 2'(mesh_router_pkg::NET_READ);
			end else if ((src_req[s].dst_addr[31:26+mesh_router_pkg::CHIP_ROW_BITS]
					!= row_ff[5:mesh_router_pkg::CHIP_ROW_BITS])
					|| (src_req[s].dst_addr[25:20+mesh_router_pkg::CHIP_COL_BITS]
					!= col_ff[5:mesh_router_pkg::CHIP_COL_BITS])) begin
				tgt[s] = 2'(mesh_router_pkg::NET_OFFCHIP);
			end else begin
				tgt[s] = 2'(mesh_router_pkg::NET_ONCHIP);
			end
			eligible[s] = src_valid[s] && slot_free[tgt[s]];
		end
		win_any = |src_grant;
		win_tgt = '0;
		win_flit = '0;
		win_data = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (src_grant[s]) begin
				win_tgt = tgt[s];
				win_data = justify(src_req[s].data, src_req[s].size);
				win_flit.dst_addr = src_req[s].dst_addr;
				win_flit.src_addr = src_req[s].src_addr;
				win_flit.data = src_req[s].write ? win_data : 64'h0;
				win_flit.size = src_req[s].size;
				win_flit.mcast = src_req[s].write && (mode_ff == mesh_router_pkg::MODE_MULTICAST);
			end
		end
	end

	// a single winner per cycle across all networks and the local memory
	rr_arbiter #(
		.N(NUM_SRC)
	) u_src_arb (
		.pclk(pclk),
		.presetn(presetn),
		.req(eligible),
		.advance(1'b1),
		.grant(src_grant)
	);

	assign src_ready = src_grant;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inj_valid_ff <= '0;
			for (int t = 0; t < NN; t++) begin
				inj_flit_ff[t] <= '0;
			end
		end else begin
			for (int t = 0; t < NN; t++) begin
				if (win_any && win_tgt == 2'(t)) begin
					inj_valid_ff[t] <= 1'b1;
					inj_flit_ff[t] <= win_flit;
				end else if (all_ready[t][LOC]) begin
					inj_valid_ff[t] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lmem_valid_ff <= 1'b0;
			lmem_req_ff <= '0;
		end else if (win_any && win_tgt == 2'h3) begin
			lmem_valid_ff <= 1'b1;
			lmem_req_ff <= src_req[0];
			for (int s = 0; s < NUM_SRC; s++) begin
				if (src_grant[s]) begin
					lmem_req_ff <= src_req[s];
				end
			end
		end else if (lmem_ready) begin
			lmem_valid_ff <= 1'b0;
		end
	end

endmodule : mesh_node_router

// *** bench/mesh_router_asserts.sv ***
`timescale 1ns/10ps
module mesh_router_asserts #(
	parameter int NUM_SRC = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	// node id and links
	input wire logic [5:0] node_row,
	input wire logic [5:0] node_col,
	input wire logic [3:0] link_out_valid [3],
	input mesh_router_pkg::flit_t link_out_flit [3][4],
	input wire logic [3:0] link_out_ready [3],
	// node side
	input wire logic [NUM_SRC-1:0] src_ready,
	input wire logic [2:0] node_out_valid,
	input mesh_router_pkg::flit_t node_out_flit [3],
	input wire logic lmem_valid,
	input mesh_router_pkg::req_t lmem_req
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_one_grant: assert property ($onehot0(src_ready))
		else $error("more than one source granted");
	a_bad_addr: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("unmapped access without error");
	a_east_route: assert property (link_out_valid[0][1] && !link_out_flit[0][1].mcast |->
		link_out_flit[0][1].dst_addr[25:20] < node_col) else $error("bad east route");
	a_west_route: assert property (link_out_valid[0][2] && !link_out_flit[0][2].mcast |->
		link_out_flit[0][2].dst_addr[25:20] > node_col) else $error("bad west route");
	a_north_route: assert property (link_out_valid[0][0] && !link_out_flit[0][0].mcast |->
		link_out_flit[0][0].dst_addr[25:20] == node_col &&
		link_out_flit[0][0].dst_addr[31:26] < node_row) else $error("bad north route");
	a_node_deliver: assert property (node_out_valid[0] && !node_out_flit[0].mcast |->
		node_out_flit[0].dst_addr[31:20] == {node_row, node_col}) else $error("bad delivery");
	a_local_decode: assert property (lmem_valid |-> lmem_req.dst_addr[31:20] == 12'h000)
		else $error("non-local address on memory port");
	for (genvar n = 0; n < 3; n++) begin : g_net
		for (genvar d = 0; d < 4; d++) begin : g_dir
			a_out_hold: assert property (link_out_valid[n][d] && !link_out_ready[n][d] |=>
				link_out_valid[n][d] && $stable(link_out_flit[n][d])) else $error("stalled flit lost");
		end
	end
	// reads leave a direction no more than once in eight cycles
	for (genvar d = 0; d < 4; d++) begin : g_rd
		a_read_gap: assert property ($rose(link_out_valid[1][d]) |=>
			!$rose(link_out_valid[1][d]) [*7]) else $error("read requests too close");
	end
	c_mcast: cover property (link_out_valid[0][0] && link_out_flit[0][0].mcast);
	c_stall: cover property (link_out_valid[0][1] && !link_out_ready[0][1]);
	c_lmem: cover property (lmem_valid);
endmodule : mesh_router_asserts

bind mesh_node_router mesh_router_asserts #(.NUM_SRC(NUM_SRC)) u_mesh_router_asserts (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pslverr(pslverr), .node_row(node_row), .node_col(node_col),
	.link_out_valid(link_out_valid), .link_out_flit(link_out_flit),
	.link_out_ready(link_out_ready), .src_ready(src_ready), .node_out_valid(node_out_valid),
	.node_out_flit(node_out_flit), .lmem_valid(lmem_valid), .lmem_req(lmem_req)
);

// *** bench/mesh_neighbour_model.sv ***
`timescale 1ns/10ps
module mesh_neighbour_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic stall,
	// readiness towards the router
	output logic [3:0] link_out_ready [3],
	output logic [2:0] node_out_ready,
	output logic lmem_ready
);
	logic tick_ff;
	// a stalled sink takes every other cycle so held flits are seen waiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= ~tick_ff;
		end
	end
	always_comb begin
		for (int n = 0; n < 3; n++) begin
			link_out_ready[n] = {4{!stall || tick_ff}};
		end
		node_out_ready = {3{!stall || tick_ff}};
		lmem_ready = !stall || tick_ff;
	end
endmodule : mesh_neighbour_model

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] node_row, node_col;
	logic [3:0] lin_v [3];
	logic [3:0] lin_r [3];
	logic [3:0] lout_v [3];
	logic [3:0] lout_r [3];
	mesh_router_pkg::flit_t lin_f [3][4];
	mesh_router_pkg::flit_t lout_f [3][4];
	mesh_router_pkg::flit_t nof [3];
	mesh_router_pkg::req_t src_req [2];
	mesh_router_pkg::req_t lmem_req;
	logic [1:0] src_valid, src_ready;
	logic [2:0] nov, nrdy;
	logic [4:0] seen;
	logic lmem_valid, lmem_ready;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int got;
	mesh_node_router #(.NUM_SRC(2)) u_mesh_node_router (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.node_row(node_row), .node_col(node_col), .link_in_valid(lin_v), .link_in_flit(lin_f),
		.link_in_ready(lin_r), .link_out_valid(lout_v), .link_out_flit(lout_f),
		.link_out_ready(lout_r), .src_valid(src_valid), .src_req(src_req),
		.src_ready(src_ready), .node_out_valid(nov), .node_out_flit(nof),
		.node_out_ready(nrdy), .lmem_valid(lmem_valid), .lmem_req(lmem_req),
		.lmem_ready(lmem_ready)
	);
	mesh_neighbour_model u_mesh_neighbour_model (.pclk(pclk), .presetn(presetn), .stall(stall),
		.link_out_ready(lout_r), .node_out_ready(nrdy), .lmem_ready(lmem_ready));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask : check
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic inject(input int s, input logic wr, input logic [31:0] a,
			input logic [63:0] d, input logic [1:0] z);
		@(posedge pclk);
		src_req[s] <= '{wr, a, 32'h08200100, d, mesh_router_pkg::size_t'(z)};
		src_valid[s] <= 1'b1;
		do begin
			@(posedge pclk);
		end while (src_ready[s] !== 1'b1);
		src_valid[s] <= 1'b0;
	endtask : inject
	task automatic send_link(input int r, input logic [31:0] a, input logic m);
		@(posedge pclk);
		lin_f[0][r] <= '{a, 32'h04100000, 64'h9, mesh_router_pkg::SIZE_DOUBLE, m};
		lin_v[0][r] <= 1'b1;
		do begin
			@(posedge pclk);
		end while (lin_r[0][r] !== 1'b1);
		lin_v[0][r] <= 1'b0;
		lin_f[0][r] <= ~lin_f[0][r];
	endtask : send_link
	task automatic expect_link(input int t, input int r, input logic [31:0] a,
			input logic [63:0] d);
		int n;
		n = 0;
		while (lout_v[t][r] !== 1'b1 && n < 30) begin
			@(negedge pclk);
			n++;
		end
		check(lout_v[t][r], 1'b1);
		check(lout_f[t][r].dst_addr, a);
		check(lout_f[t][r].data, d);
	endtask : expect_link
	task automatic watch;
		seen = '0;
		got = 0;
		q = '0;
		repeat (20) begin
			@(negedge pclk);
			seen |= {nov[0], lout_v[0]};
			got += int'(lmem_valid && lmem_ready);
			if (lmem_valid) q ^= lmem_req.dst_addr;
			if (nov[0]) q ^= nof[0].dst_addr;
		end
	endtask : watch
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, mesh_router_pkg::REG_MODE, 32'h0);
		check(q, mesh_router_pkg::MODE_RST);
		apb(1'b0, mesh_router_pkg::REG_OVR_READ, 32'h0);
		check(q, mesh_router_pkg::OVR_RST);
		apb(1'b0, 12'h020, 32'h0);
		check({e, q}, 33'h100000000);
		apb(1'b1, mesh_router_pkg::REG_OVR_ONCHIP, mesh_router_pkg::OVR_BLOCK);
		inject(0, 1'b1, 32'h04100008, 64'h1, 2'h3);
		watch();
		check(seen, 5'h00);
		apb(1'b1, mesh_router_pkg::REG_OVR_ONCHIP, mesh_router_pkg::OVR_NORMAL);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_route;
		logic [31:0] ad [4] = '{32'h0c200001, 32'h04200002, 32'h08300004, 32'h04100008};
		int dr [4] = '{3, 0, 2, 1};
		logic [63:0] m;
		stall <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			m = (i == 3) ? '1 : (64'h1 << (8 << i)) - 64'h1;
			inject(0, 1'b1, ad[i], 64'h1122334455667788, i[1:0]);
			expect_link(0, dr[i], ad[i], 64'h1122334455667788 & m);
		end
		@(posedge pclk) stall <= 1'b0;
		$display("t_route done");
	endtask : t_route
	task automatic t_read;
		int c0;
		inject(0, 1'b0, 32'h0c200008, 64'hffff, 2'h3);
		expect_link(1, 3, 32'h0c200008, 64'h0);
		check(lout_f[1][3].src_addr, 32'h08200100);
		c0 = cyc;
		inject(1, 1'b0, 32'h0c200010, 64'h0, 2'h3);
		expect_link(1, 3, 32'h0c200010, 64'h0);
		check(cyc - c0 >= 8, 1'b1);
		$display("t_read done");
	endtask : t_read
	task automatic t_local;
		fork
			inject(0, 1'b1, 32'h00000010, 64'h5, 2'h2);
			inject(1, 1'b1, 32'h00000020, 64'h6, 2'h2);
			watch();
		join
		check(got, 2);
		check(seen, 5'h00);
		check(q, 32'h00000030);
		$display("t_local done");
	endtask : t_local
	task automatic t_mcast;
		apb(1'b1, mesh_router_pkg::REG_MODE, 32'h3);
		apb(1'b1, mesh_router_pkg::REG_GROUP, 32'h0c300100);
		fork
			inject(0, 1'b1, 32'h0c300100, 64'h9, 2'h3);
			watch();
		join
		check(seen, 5'h0f);
		apb(1'b1, mesh_router_pkg::REG_MODE, 32'h0);
		fork
			send_link(1, 32'h0c300100, 1'b1);
			watch();
		join
		check(seen, 5'h1d);
		check(q, 32'h0c300100);
		fork
			send_link(1, 32'h08200040, 1'b0);
			watch();
		join
		check(seen, 5'h10);
		$display("t_mcast done");
	endtask : t_mcast
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, stall} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		node_row = 6'h02;
		node_col = 6'h02;
		src_valid = 2'h0;
		src_req = '{default: '0};
		lin_v = '{default: '0};
		lin_f = '{default: '0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_regs();
		t_route();
		t_read();
		t_local();
		t_mcast();
		final_report();
	end
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
endmodule : tb
